// ===== design/adcc_top.sv
// Converter control block: AXI4-Lite registers, pin muxing, conversion timing.
// Assumes a converter core that presents a 12-bit sample when asked.
//
// Implementation choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "adcc_consts.svh"

module adcc_top
  import adcc_pkg::*;
#(
  parameter int NPINS = 4
)(
  input  wire logic                  ref_clk,
  input  wire logic                  reset_n,
  input  wire logic [7:0]            s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [7:0]            s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire adcc_pkg::adcc_result_t coreResult,
  output logic                       corePowerOn,
  output logic                       coreReset,
  output logic                       coreSample,
  output logic [2:0]                 coreChannel,
  output logic                       refFromPin,
  output logic [NPINS-1:0]           pinAnalog,
  output logic [NPINS-1:0]           pinDigitalEn,
  output logic [NPINS-1:0]           pinOutEn,
  output logic [NPINS-1:0]           pinPullHigh,
  output logic                       irq
);
  import adcc_pkg::*;

  // ****************************************
  // Register state
  // ****************************************
  logic [7:0]       ctrl0_q;
  logic [7:0]       ctrl1_q;
  logic [NPINS-1:0] pinEn_q;
  logic [NPINS-1:0] portDir_q;
  logic [NPINS-1:0] pullHi_q;
  adcc_result_t     result_q;
  logic             irqFlag_q;
  logic [1:0]       irqEn_q;
  logic             busy_q;
  adcc_state_e      state_q;
  logic [4:0]       tickCnt_q;
  logic             startPrev_q;

  logic        awHeld_q;
  logic        wHeld_q;
  logic [7:0]  awAddr_q;
  logic [31:0] wData_q;
  logic [3:0]  wStrb_q;
  logic        bValid_q;
  logic        bErr_q;
  logic        rValid_q;
  logic [31:0] rData_q;
  logic        rErr_q;

  logic        wrFire;
  logic        wrHit;
  logic [7:0]  wByte;
  logic        startBit;
  logic        powerOff;
  logic        convTick;
  logic        convDone;
  logic        rdHit;
  logic [31:0] rdWord;

  // ****************************************
  // AXI4-Lite write channel
  // ****************************************
  // Address and data are latched independently so either may arrive first.
  assign s_axi_awready = !awHeld_q && !bValid_q;
  assign s_axi_wready  = !wHeld_q && !bValid_q;
  assign wrFire        = awHeld_q && wHeld_q && !bValid_q;
  assign wByte         = wData_q[7:0];
  assign s_axi_bvalid  = bValid_q;
  assign s_axi_bresp   = bErr_q ? 2'h2 : 2'h0;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      awHeld_q <= 1'b0;
      awAddr_q <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      awHeld_q <= 1'b1;
      awAddr_q <= s_axi_awaddr;
    end else if (wrFire) begin
      awHeld_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      wHeld_q <= 1'b0;
      wData_q <= 32'h0000_0000;
      wStrb_q <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      wHeld_q <= 1'b1;
      wData_q <= s_axi_wdata;
      wStrb_q <= s_axi_wstrb;
    end else if (wrFire) begin
      wHeld_q <= 1'b0;
    end
  end

  always_comb begin
    unique case (awAddr_q)
      `ADCC_OFF_CTRL0, `ADCC_OFF_CTRL1, `ADCC_OFF_PINEN, `ADCC_OFF_RESLO,
      `ADCC_OFF_RESHI, `ADCC_OFF_IRQSTAT, `ADCC_OFF_IRQCLR, `ADCC_OFF_IRQEN,
      `ADCC_OFF_PORTDIR, `ADCC_OFF_PULLHI: wrHit = 1'b1;
      default: wrHit = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      bValid_q <= 1'b0;
      bErr_q   <= 1'b0;
    end else if (wrFire) begin
      bValid_q <= 1'b1;
      bErr_q   <= !wrHit;
    end else if (s_axi_bready) begin
      bValid_q <= 1'b0;
    end
  end

  // ****************************************
  // Control registers
  // ****************************************
  // Only byte lane 0 carries register bits; other lanes are ignored.
  function automatic logic wrTo(input logic [7:0] off);
    wrTo = wrFire && awAddr_q == off && wStrb_q[0];
  endfunction

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl0_q <= `ADCC_RST_CTRL0;
    end else if (wrTo(`ADCC_OFF_CTRL0)) begin
      ctrl0_q <= {wByte[7], 1'b0, wByte[5:0]};
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl1_q <= `ADCC_RST_CTRL1;
    end else if (wrTo(`ADCC_OFF_CTRL1)) begin
      ctrl1_q <= wByte;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pinEn_q   <= NPINS'(`ADCC_RST_PINEN);
      portDir_q <= NPINS'(`ADCC_RST_PORTDIR);
      pullHi_q  <= NPINS'(`ADCC_RST_PULLHI);
      irqEn_q   <= 2'h0;
    end else begin
      if (wrTo(`ADCC_OFF_PINEN)) begin
        pinEn_q <= wByte[NPINS-1:0];
      end
      if (wrTo(`ADCC_OFF_PORTDIR)) begin
        portDir_q <= wByte[NPINS-1:0];
      end
      if (wrTo(`ADCC_OFF_PULLHI)) begin
        pullHi_q <= wByte[NPINS-1:0];
      end
      if (wrTo(`ADCC_OFF_IRQEN)) begin
        irqEn_q <= wByte[1:0];
      end
    end
  end

  assign startBit = ctrl0_q[`ADCC_C0_START];
  assign powerOff = ctrl0_q[`ADCC_C0_POWOFF];

  // ****************************************
  // Pin and converter steering
  // ****************************************
  // Port direction 1 means input; analog pins are forced to input.
  assign pinAnalog    = pinEn_q;
  assign pinDigitalEn = ~pinEn_q;
  assign pinOutEn     = ~portDir_q & ~pinEn_q;
  assign pinPullHigh  = pullHi_q & ~pinEn_q;
  assign refFromPin   = ctrl1_q[`ADCC_C1_REFSEL];
  assign coreChannel  = {ctrl1_q[`ADCC_C1_CHHI],
                         ctrl0_q[`ADCC_C0_CHLO_LSB+1:`ADCC_C0_CHLO_LSB]};
  assign corePowerOn  = !powerOff;
  assign coreReset    = powerOff || (state_q == ADCC_ARMED);

  // ****************************************
  // Conversion sequencer
  // ****************************************
  adcc_clock_div u_div (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .divSel  (ctrl1_q[`ADCC_C1_CLKDIV_LSB+2:`ADCC_C1_CLKDIV_LSB]),
    .run     (state_q == ADCC_CONV),
    .tick    (convTick)
  );

  // Power-off or a fresh start in the final cycle cancels the completion.
  assign convDone   = !powerOff && !startBit && state_q == ADCC_CONV && convTick
                      && tickCnt_q == `ADCC_CONV_CLOCKS - 5'h01;
  assign coreSample = convDone;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      startPrev_q <= 1'b0;
    end else begin
      startPrev_q <= startBit;
    end
  end

  // A rising start arms and resets; the falling edge launches the count.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q   <= ADCC_IDLE;
      tickCnt_q <= 5'h00;
      busy_q    <= 1'b0;
    end else if (powerOff) begin
      state_q   <= ADCC_IDLE;
      tickCnt_q <= 5'h00;
      busy_q    <= 1'b0;
    end else if (startBit && !startPrev_q) begin
      state_q   <= ADCC_ARMED;
      tickCnt_q <= 5'h00;
      busy_q    <= 1'b1;
    end else begin
      unique case (state_q)
        ADCC_IDLE: begin
          tickCnt_q <= 5'h00;
        end
        ADCC_ARMED: begin
          if (!startBit) begin
            state_q <= ADCC_CONV;
          end
        end
        ADCC_CONV: begin
          if (convDone) begin
            state_q <= ADCC_IDLE;
            busy_q  <= 1'b0;
          end else if (convTick) begin
            tickCnt_q <= tickCnt_q + 5'h01;
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      result_q <= 12'h000;
    end else if (convDone) begin
      result_q <= coreResult;
    end
  end

  // ****************************************
  // Interrupt
  // ****************************************
  // Set wins over a clear in the same cycle so no completion is lost.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      irqFlag_q <= 1'b0;
    end else if (convDone) begin
      irqFlag_q <= 1'b1;
    end else if (wrTo(`ADCC_OFF_IRQCLR) && wByte[0]) begin
      irqFlag_q <= 1'b0;
    end
  end

  assign irq = irqFlag_q && irqEn_q[`ADCC_IE_CONV] && irqEn_q[`ADCC_IE_GLOBAL];

  // ****************************************
  // AXI4-Lite read channel
  // ****************************************
  always_comb begin
    rdHit  = 1'b1;
    rdWord = 32'h0000_0000;
    unique case (s_axi_araddr)
      `ADCC_OFF_CTRL0:   rdWord[7:0] = {ctrl0_q[7], busy_q, ctrl0_q[5:0]};
      `ADCC_OFF_CTRL1:   rdWord[7:0] = ctrl1_q;
      `ADCC_OFF_PINEN:   rdWord[NPINS-1:0] = pinEn_q;
      `ADCC_OFF_RESLO:   rdWord[7:0] = result_q[7:0];
      `ADCC_OFF_RESHI:   rdWord[3:0] = result_q[11:8];
      `ADCC_OFF_IRQSTAT: rdWord[0] = irqFlag_q;
      `ADCC_OFF_IRQCLR:  rdWord = 32'h0000_0000;
      `ADCC_OFF_IRQEN:   rdWord[1:0] = irqEn_q;
      `ADCC_OFF_PORTDIR: rdWord[NPINS-1:0] = portDir_q;
      `ADCC_OFF_PULLHI:  rdWord[NPINS-1:0] = pullHi_q;
      default:           rdHit = 1'b0;
    endcase
  end

  assign s_axi_arready = !rValid_q;
  assign s_axi_rvalid  = rValid_q;
  assign s_axi_rdata   = rData_q;
  assign s_axi_rresp   = rErr_q ? 2'h2 : 2'h0;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rValid_q <= 1'b0;
      rData_q  <= 32'h0000_0000;
      rErr_q   <= 1'b0;
    end else if (s_axi_arvalid && !rValid_q) begin
      rValid_q <= 1'b1;
      rData_q  <= rdWord;
      rErr_q   <= !rdHit;
    end else if (s_axi_rready) begin
      rValid_q <= 1'b0;
    end
  end
endmodule

`default_nettype wire

// ===== design/adcc_consts.svh
// Constants for the converter control block: offsets, fields, resets, timing.
// Assumes inclusion by bare name from the package and design modules.
`ifndef ADCC_CONSTS_SVH
`define ADCC_CONSTS_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define ADCC_OFF_CTRL0     8'h00
`define ADCC_OFF_CTRL1     8'h04
`define ADCC_OFF_PINEN     8'h08
`define ADCC_OFF_RESLO     8'h0c
`define ADCC_OFF_RESHI     8'h10
`define ADCC_OFF_IRQSTAT   8'h14
`define ADCC_OFF_IRQCLR    8'h18
`define ADCC_OFF_IRQEN     8'h1c
`define ADCC_OFF_PORTDIR   8'h20
`define ADCC_OFF_PULLHI    8'h24

// ****************************************
// Field positions
// ****************************************
`define ADCC_C0_CHLO_LSB   0
`define ADCC_C0_POWOFF     5
`define ADCC_C0_BUSY       6
`define ADCC_C0_START      7
`define ADCC_C1_CLKDIV_LSB 0
`define ADCC_C1_REFSEL     3
`define ADCC_C1_CHHI       4
`define ADCC_IE_CONV       0
`define ADCC_IE_GLOBAL     1

// ****************************************
// Reset values
// ****************************************
`define ADCC_RST_CTRL0     8'h60
`define ADCC_RST_CTRL1     8'h00
`define ADCC_RST_PINEN     4'h0
`define ADCC_RST_PORTDIR   4'hf
`define ADCC_RST_PULLHI    4'h0

// ****************************************
// Timing
// ****************************************
`define ADCC_CONV_CLOCKS   5'h10
`define ADCC_DIV_UNDEF     3'h7

`endif

// ===== design/adcc_pkg.sv
// Types shared by the converter control design files.
// Assumes adcc_consts.svh sits on the include path.
`include "adcc_consts.svh"

package adcc_pkg;
  typedef logic [2:0]  adcc_div_t;
  typedef logic [11:0] adcc_result_t;
  typedef enum logic [1:0] {ADCC_IDLE, ADCC_ARMED, ADCC_CONV} adcc_state_e;
endpackage

// ===== design/adcc_clock_div.sv
// Converter clock tick generator from the system clock.
// Assumes one clock domain; the tick is a one-cycle enable pulse.
`timescale 1ns/1ps
`default_nettype none
`include "adcc_consts.svh"

module adcc_clock_div
  import adcc_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              reset_n,
  input  wire adcc_pkg::adcc_div_t divSel,
  input  wire logic              run,
  output logic                   tick
);
  import adcc_pkg::*;

  logic [5:0] cnt_q;
  logic [5:0] limit;

  // ****************************************
  // Divider
  // ****************************************
  // Codes 000..110 give divide by 1..64; 111 is undefined and stops ticking.
  always_comb begin
    limit = 6'((7'h01 << divSel) - 7'h01);
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q <= 6'h00;
    end else if (!run || cnt_q == limit) begin
      cnt_q <= 6'h00;
    end else begin
      cnt_q <= cnt_q + 6'h01;
    end
  end

  assign tick = run && (divSel != `ADCC_DIV_UNDEF) && (cnt_q == limit);
endmodule

`default_nettype wire

// ===== dv/adcc_properties.sv
// Port checker for the converter control block.
// Assumes it is bound to adcc_top and shares its single clock.
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Checker
// ****************************************
module adcc_properties #(
  parameter int NPINS = 4
)(
  input wire logic             ref_clk,
  input wire logic             reset_n,
  input wire logic             s_axi_awvalid,
  input wire logic             s_axi_awready,
  input wire logic             s_axi_wvalid,
  input wire logic             s_axi_wready,
  input wire logic [1:0]       s_axi_bresp,
  input wire logic             s_axi_bvalid,
  input wire logic             s_axi_arvalid,
  input wire logic             s_axi_arready,
  input wire logic             s_axi_rvalid,
  input wire logic             corePowerOn,
  input wire logic             coreReset,
  input wire logic             coreSample,
  input wire logic [NPINS-1:0] pinAnalog,
  input wire logic [NPINS-1:0] pinDigitalEn,
  input wire logic [NPINS-1:0] pinOutEn,
  input wire logic [NPINS-1:0] pinPullHigh,
  input wire logic             irq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  logic [15:0] sinceArm_q;
  // Counts cycles since the core was last held, so no sample can come early.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) sinceArm_q <= 16'h0000;
    else if (coreReset) sinceArm_q <= 16'h0000;
    else if (sinceArm_q != 16'hffff) sinceArm_q <= sinceArm_q + 16'h0001;
  end
  a_pin_route: assert property (pinDigitalEn == ~pinAnalog)
    else $error("digital path open on analog pin");
  a_pull_drop: assert property ((pinPullHigh & pinAnalog) == '0)
    else $error("pull-high left on analog pin");
  a_dir_override: assert property ((pinOutEn & pinAnalog) == '0)
    else $error("analog pin still driven");
  a_off_held: assert property (!corePowerOn |-> coreReset && !coreSample)
    else $error("core active while powered off");
  a_conv_length: assert property (coreSample |-> sinceArm_q >= 16'h000f)
    else $error("conversion ended too early");
  a_sample_pulse: assert property (coreSample |=> !coreSample)
    else $error("completion pulse too long");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write response missing");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response missing");
  c_irq_done: cover property (coreSample ##1 irq);
  c_poll_done: cover property (coreSample ##1 !irq);
  c_bad_write: cover property (s_axi_bvalid && s_axi_bresp == 2'b10);
endmodule
bind adcc_top adcc_properties #(.NPINS(NPINS)) chk (.ref_clk, .reset_n, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .corePowerOn, .coreReset, .coreSample, .pinAnalog,
  .pinDigitalEn, .pinOutEn, .pinPullHigh, .irq);
`default_nettype wire

// ===== dv/adcc_core_model.sv
// Behavioural converter core on the far side of the block.
// Assumes the bench sets the analog level it should convert.
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Core model
// ****************************************
module adcc_core_model
  import adcc_pkg::*;
(
  input  wire logic                   ref_clk,
  input  wire logic                   corePowerOn,
  input  wire logic                   coreReset,
  input  wire adcc_pkg::adcc_result_t analogLevel,
  output adcc_pkg::adcc_result_t      coreResult
);
  adcc_result_t junk_q = 12'h5a5;
  // An unpowered or held core has no valid sample, so its output churns.
  always @(posedge ref_clk) junk_q <= ~junk_q;
  assign coreResult = (corePowerOn && !coreReset) ? analogLevel : junk_q;
endmodule
`default_nettype wire

// ===== dv/adc_conversion_control_test.sv
// Self-checking bench for the converter control block.
// Assumes design, core model and checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Bench
// ****************************************
module adc_conversion_control_test;
  import adcc_pkg::*;
  logic         ref_clk = 1'b0, reset_n = 1'b0;
  logic [7:0]   s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic         s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic         s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, rf;
  logic [31:0]  s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]   s_axi_wstrb = 4'hf;
  adcc_result_t analogLevel = 12'h000, coreResult, lvl;
  logic         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]   s_axi_bresp, s_axi_rresp, lastResp;
  logic         corePowerOn, coreReset, coreSample, refFromPin, irq;
  logic [2:0]   coreChannel, ch;
  logic [3:0]   pinAnalog, pinDigitalEn, pinOutEn, pinPullHigh, pe, pd, ph;
  int           fail_count = 0, compares = 0, cycles = 0, n;
  int           expQ[$], e;
  initial forever #2.5 ref_clk = ~ref_clk;
  adcc_top #(.NPINS(4)) uut (.ref_clk, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .coreResult, .corePowerOn, .coreReset, .coreSample,
    .coreChannel, .refFromPin, .pinAnalog, .pinDigitalEn, .pinOutEn, .pinPullHigh, .irq);
  adcc_core_model core (.ref_clk, .corePowerOn, .coreReset, .analogLevel, .coreResult);
  task automatic give_verdict;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    lastResp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    @(posedge ref_clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    lastResp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    check(s_axi_rdata, e);
  endtask
  // A hung handshake must still end the run with a verdict.
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      give_verdict();
    end
  end
  initial begin
    void'($urandom(32'h1cad8c62));
    repeat (8) @(posedge ref_clk);
    reset_n <= 1'b1;
    check(corePowerOn, 32'h0);
    rchk(8'h00, 32'h20);
    rchk(8'h20, 32'hf);
    for (int i = 0; i < 6; i++) begin
      pe = 4'($urandom);
      pd = 4'($urandom);
      ph = 4'($urandom);
      wr(8'h08, {28'h0, pe});
      wr(8'h20, {28'h0, pd});
      wr(8'h24, {28'h0, ph});
      check({28'h0, pinAnalog}, {28'h0, pe});
      check({28'h0, pinDigitalEn}, {28'h0, ~pe});
      check({28'h0, pinOutEn}, {28'h0, ~pd & ~pe});
      check({28'h0, pinPullHigh}, {28'h0, ph & ~pe});
    end
    // Every divider code from the plain clock to the slowest, last at full scale.
    for (int i = 0; i < 7; i++) begin
      ch = 3'($urandom);
      rf = 1'($urandom);
      lvl = (i == 6) ? 12'hfff : 12'($urandom);
      analogLevel <= lvl;
      expQ.push_back(int'(lvl));
      wr(8'h04, {27'h0, ch[2], rf, 3'(i)});
      wr(8'h00, 32'h0);
      check(corePowerOn, 32'h1);
      wr(8'h1c, {30'h0, 2'(i)});
      wr(8'h00, {24'h0, 6'h30, ch[1:0]});
      rchk(8'h00, {24'h0, 6'h30, ch[1:0]});
      check(coreReset, 32'h1);
      check({29'h0, coreChannel}, {29'h0, ch});
      check(refFromPin, {31'h0, rf});
      wr(8'h00, {30'h0, ch[1:0]});
      n = 0;
      while (!coreSample) begin
        @(posedge ref_clk);
        n++;
      end
      check({31'h0, n >= (15 << i) && n <= (17 << i) + 4}, 32'h1);
      rchk(8'h00, {30'h0, ch[1:0]});
      e = expQ.pop_front();
      rchk(8'h0c, {24'h0, e[7:0]});
      rchk(8'h10, {28'h0, e[11:8]});
      rchk(8'h14, 32'h1);
      check(irq, {31'h0, i[1:0] == 2'b11});
      wr(8'h18, 32'h1);
      rchk(8'h14, 32'h0);
      check(irq, 32'h0);
    end
    // The undefined divider code stalls; powering off is the way out.
    wr(8'h04, 32'h7);
    wr(8'h00, 32'h80);
    wr(8'h00, 32'h0);
    repeat (200) @(posedge ref_clk);
    rchk(8'h00, 32'h40);
    wr(8'h00, 32'h20);
    rchk(8'h00, 32'h20);
    check(corePowerOn, 32'h0);
    rchk(8'h3c, 32'h0);
    check({30'h0, lastResp}, 32'h2);
    wr(8'h40, 32'hff);
    check({30'h0, lastResp}, 32'h2);
    give_verdict();
  end
endmodule
`default_nettype wire
